// file: hdl/olx_pkg.sv
// shared constants and types for the or/move/pointer-load executor
package olx_pkg;
   // ----------------------------------------------------------------
   // opcode prefixes
   // ----------------------------------------------------------------
   localparam int         INSTR_W      = 16;
   localparam int         PREFIX6_LSB  = 10;
   localparam int         LOAD_LSB     = 6;
   localparam logic [5:0] OR_PREFIX    = 6'h04;   // 0001 00
   localparam logic [5:0] MOVE_PREFIX  = 6'h14;   // 0101 00
   localparam logic [9:0] LOAD_PREFIX  = 10'h3B8; // 1110 1110 00

   // ----------------------------------------------------------------
   // instruction fields
   // ----------------------------------------------------------------
   localparam int         D_BIT        = 9;
   localparam int         A_BIT        = 8;
   localparam int         SEL_LSB      = 4;
   localparam int         SEL_W        = 2;
   localparam int         BYTE_W       = 8;
   localparam int         SIGN_BIT     = 7;

   // ----------------------------------------------------------------
   // addressing
   // ----------------------------------------------------------------
   localparam int         BANK_W       = 4;
   localparam int         ADDR_W       = 12;
   localparam logic [7:0] IDX_LIMIT    = 8'h5F;
   localparam logic [3:0] ACCESS_LOWER = 4'h0;
   localparam logic [3:0] ACCESS_UPPER = 4'hF;
   localparam logic [7:0] ZERO_BYTE    = 8'h00;

   // ----------------------------------------------------------------
   // pointer registers
   // ----------------------------------------------------------------
   localparam int         PTR_NUM      = 3;
   localparam int         PTR_W        = 12;
   localparam int         PTR_HI_W     = 4;
   localparam logic [1:0] IDX_PTR_SEL  = 2'h2;
   localparam logic [11:0] PTR_RESET   = 12'h000;

   typedef enum logic [0:0] {
      OLX_ST_FIRST = 1'b0,
      OLX_ST_LOW   = 1'b1
   } olx_state_type;
endpackage

// file: hdl/olx_ptr_bank.sv
// bank of indirect pointer registers with separate high nibble and low byte writes
`timescale 1ns/1ps
module olx_ptr_bank #(
   parameter int NUM   = olx_pkg::PTR_NUM,
   parameter int WIDTH = olx_pkg::PTR_W,
   parameter int HI_W  = olx_pkg::PTR_HI_W
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_reset_n,
   input  wire logic                   i_we_hi,
   input  wire logic                   i_we_lo,
   input  wire logic [1:0]             i_sel,
   input  wire logic [HI_W-1:0]        i_hi,
   input  wire logic [WIDTH-HI_W-1:0]  i_lo,
   output logic      [NUM*WIDTH-1:0]   o_ptrs
);
   // ----------------------------------------------------------------
   // one register per pointer; select codes NUM and above write nothing
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM; g++) begin : g_ptr
      logic [WIDTH-1:0] ptr_r;
      logic [WIDTH-1:0] ptr_nxt;

      // byte-wise update of the selected pointer
      always_comb begin
         ptr_nxt = ptr_r;
         if (i_we_hi && (i_sel == 2'(g))) begin
            ptr_nxt[WIDTH-1 -: HI_W] = i_hi;
         end
         if (i_we_lo && (i_sel == 2'(g))) begin
            ptr_nxt[WIDTH-HI_W-1:0] = i_lo;
         end
      end

      // pointer storage
      always_ff @(posedge i_clk or negedge i_reset_n) begin
         if (!i_reset_n) begin
            ptr_r <= olx_pkg::PTR_RESET;
         end else begin
            ptr_r <= ptr_nxt;
         end
      end

      assign o_ptrs[g*WIDTH +: WIDTH] = ptr_r;
   end
endmodule

// file: hdl/olx_instr_exec.sv
// decode and execute of or-with-file, move-file and pointer-load instructions
//
// Functional notes
// RULE_01: or-with-file ORs working reg with file
// RULE_02: destination bit zero to W, one to file
// RULE_03: bank-access bit zero uses access bank
// RULE_04: bank-access bit one uses bank select
// RULE_05: extended set, low address: indexed literal offset
// RULE_06: pointer-load puts 12-bit literal in pointer
// RULE_07: pointer-load decoded by prefix, select, literal
// RULE_08: move-file copies file register to destination
// RULE_09: move-file address reaches whole 256-byte bank
// RULE_10: pointer-load: high byte first, low second
`timescale 1ns/1ps
module olx_instr_exec (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_instr_valid,
   input  wire logic [15:0] i_instr,
   input  wire logic [7:0]  i_w_data,
   input  wire logic [7:0]  i_file_rdata,
   input  wire logic [3:0]  i_bank_sel,
   input  wire logic        i_ext_en,
   output logic      [11:0] o_file_raddr,
   output logic             o_file_re,
   output logic      [11:0] o_file_waddr,
   output logic             o_file_we,
   output logic             o_w_we,
   output logic      [7:0]  o_result,
   output logic             o_stat_we,
   output logic             o_stat_n,
   output logic             o_stat_z,
   output logic             o_second_word,
   output logic      [35:0] o_ptrs
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // pick one pointer from the flat bus; unused codes read as zero
   function automatic logic [11:0] get_ptr(input logic [35:0] flat,
                                           input logic [1:0]  sel);
      logic [11:0] p;
      p = olx_pkg::PTR_RESET;
      if (int'(sel) < olx_pkg::PTR_NUM) begin
         p = flat[int'(sel)*olx_pkg::PTR_W +: olx_pkg::PTR_W];
      end
      return p;
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   olx_pkg::olx_state_type state_r, state_nxt;
   logic [1:0]  sel_r, sel_nxt;
   logic        s1_valid_r, s1_valid_nxt;
   logic        s1_or_r, s1_or_nxt;
   logic        s1_dest_r, s1_dest_nxt;
   logic [11:0] raddr_r, raddr_nxt;
   logic [11:0] waddr_r, waddr_nxt;
   logic        file_we_r, file_we_nxt;
   logic        w_we_r, w_we_nxt;
   logic [7:0]  result_r, result_nxt;
   logic        stat_we_r, stat_we_nxt;
   logic        take_or, take_mov, take_hi, take_lo;
   logic        first_word, bit_a, bit_d, use_idx;
   logic [7:0]  f_addr;
   logic [1:0]  word_sel;
   logic [11:0] idx_addr, cur_ptr;

   // ----------------------------------------------------------------
   // instruction decode
   // ----------------------------------------------------------------
   // first words decode as opcodes; a second word is only literal
   always_comb begin
      first_word = i_instr_valid && (state_r == olx_pkg::OLX_ST_FIRST);
      take_or    = first_word && (i_instr[olx_pkg::INSTR_W-1:olx_pkg::PREFIX6_LSB]
                                  == olx_pkg::OR_PREFIX);                 // [RULE_01]
      take_mov   = first_word && (i_instr[olx_pkg::INSTR_W-1:olx_pkg::PREFIX6_LSB]
                                  == olx_pkg::MOVE_PREFIX);               // [RULE_08]
      take_hi    = first_word && (i_instr[olx_pkg::INSTR_W-1:olx_pkg::LOAD_LSB]
                                  == olx_pkg::LOAD_PREFIX);               // [RULE_07]
      take_lo    = i_instr_valid && (state_r == olx_pkg::OLX_ST_LOW);   // [RULE_10]
      bit_a      = i_instr[olx_pkg::A_BIT];
      bit_d      = i_instr[olx_pkg::D_BIT];
      f_addr     = i_instr[olx_pkg::BYTE_W-1:0];
      word_sel   = i_instr[olx_pkg::SEL_LSB +: olx_pkg::SEL_W];
      use_idx    = !bit_a && i_ext_en && (f_addr <= olx_pkg::IDX_LIMIT);
   end

   // indexed base is pointer two plus the 8-bit offset
   assign idx_addr = get_ptr(o_ptrs, olx_pkg::IDX_PTR_SEL)
                     + {{olx_pkg::PTR_HI_W{1'b0}}, f_addr};               // [RULE_05]
   assign cur_ptr  = get_ptr(o_ptrs, sel_r);

   // ----------------------------------------------------------------
   // pointer-load sequencer
   // ----------------------------------------------------------------
   // first word loads high part, next word the low byte
   always_comb begin
      state_nxt = state_r;
      sel_nxt   = sel_r;
      if (take_hi) begin
         state_nxt = olx_pkg::OLX_ST_LOW;                                  // [RULE_10]
         sel_nxt   = word_sel;                                             // [RULE_06]
      end else if (take_lo) begin
         state_nxt = olx_pkg::OLX_ST_FIRST;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r <= olx_pkg::OLX_ST_FIRST;
         sel_r   <= olx_pkg::IDX_PTR_SEL;
      end else begin
         state_r <= state_nxt;
         sel_r   <= sel_nxt;
      end
   end

   // pointer storage, written byte by byte
   olx_ptr_bank #(
      .NUM   (olx_pkg::PTR_NUM),
      .WIDTH (olx_pkg::PTR_W),
      .HI_W  (olx_pkg::PTR_HI_W)
   ) u_ptr_bank (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_we_hi   (take_hi),                                               // [RULE_10]
      .i_we_lo   (take_lo),
      .i_sel     (take_hi ? word_sel : sel_r),                            // [RULE_06]
      .i_hi      (i_instr[olx_pkg::PTR_HI_W-1:0]),
      .i_lo      (f_addr),
      .o_ptrs    (o_ptrs)
   );

   // ----------------------------------------------------------------
   // stage 1: address resolution and file read
   // ----------------------------------------------------------------
   always_comb begin
      s1_valid_nxt = take_or || take_mov;
      s1_or_nxt    = take_or;
      s1_dest_nxt  = bit_d;
      if (bit_a) begin
         raddr_nxt = {i_bank_sel, f_addr};                     // [RULE_04] [RULE_09]
      end else if (use_idx) begin
         raddr_nxt = idx_addr;                                             // [RULE_05]
      end else if (f_addr <= olx_pkg::IDX_LIMIT) begin
         raddr_nxt = {olx_pkg::ACCESS_LOWER, f_addr};                      // [RULE_03]
      end else begin
         raddr_nxt = {olx_pkg::ACCESS_UPPER, f_addr};                      // [RULE_03]
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s1_valid_r <= 1'b0;
         s1_or_r    <= 1'b0;
         s1_dest_r  <= 1'b0;
         raddr_r    <= olx_pkg::PTR_RESET;
      end else begin
         s1_valid_r <= s1_valid_nxt;
         s1_or_r    <= s1_or_nxt;
         s1_dest_r  <= s1_dest_nxt;
         raddr_r    <= raddr_nxt;
      end
   end

   // ----------------------------------------------------------------
   // stage 2: compute and write back
   // ----------------------------------------------------------------
   always_comb begin
      result_nxt  = result_r;
      waddr_nxt   = waddr_r;
      stat_we_nxt = s1_valid_r;
      w_we_nxt    = s1_valid_r && !s1_dest_r;                              // [RULE_02]
      file_we_nxt = s1_valid_r && s1_dest_r;                               // [RULE_02]
      if (s1_valid_r) begin
         waddr_nxt  = raddr_r;
         result_nxt = s1_or_r ? (i_w_data | i_file_rdata)                  // [RULE_01]
                              : i_file_rdata;                              // [RULE_08]
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         result_r  <= olx_pkg::ZERO_BYTE;
         waddr_r   <= olx_pkg::PTR_RESET;
         stat_we_r <= 1'b0;
         w_we_r    <= 1'b0;
         file_we_r <= 1'b0;
      end else begin
         result_r  <= result_nxt;
         waddr_r   <= waddr_nxt;
         stat_we_r <= stat_we_nxt;
         w_we_r    <= w_we_nxt;
         file_we_r <= file_we_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_file_raddr  = raddr_r;
   assign o_file_re     = s1_valid_r;
   assign o_file_waddr  = waddr_r;
   assign o_file_we     = file_we_r;
   assign o_w_we        = w_we_r;
   assign o_result      = result_r;
   assign o_stat_we     = stat_we_r;
   assign o_stat_n      = result_r[olx_pkg::SIGN_BIT];
   assign o_stat_z      = (result_r == olx_pkg::ZERO_BYTE);
   assign o_second_word = (state_r == olx_pkg::OLX_ST_LOW);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   a_or_result: assert property (s1_valid_r && s1_or_r |=> // [RULE_01]
      o_result == ($past(i_w_data) | $past(i_file_rdata)))
      else $error("or result wrong");
   a_move_copy: assert property (s1_valid_r && !s1_or_r |=> // [RULE_08]
      o_result == $past(i_file_rdata) && o_stat_we)
      else $error("move result wrong");
   a_dest_select: assert property ((take_or || take_mov) |-> ##2 // [RULE_02]
      (o_w_we == !$past(bit_d, 2)) && (o_file_we == $past(bit_d, 2))
      && (o_file_waddr == $past(o_file_raddr)))
      else $error("destination wrong");
   a_access_bank: assert property ((take_or || take_mov) && !bit_a && !use_idx // [RULE_03]
      |=> o_file_raddr[7:0] == $past(f_addr) && o_file_raddr[11:8] ==
      (($past(f_addr) <= olx_pkg::IDX_LIMIT) ? olx_pkg::ACCESS_LOWER : olx_pkg::ACCESS_UPPER))
      else $error("access bank address wrong");
   a_banked_addr: assert property ((take_or || take_mov) && bit_a // [RULE_04]
      |=> o_file_raddr == {$past(i_bank_sel), $past(f_addr)} && o_file_re)
      else $error("banked address wrong");
   a_indexed_addr: assert property ((take_or || take_mov) && use_idx // [RULE_05]
      |=> o_file_raddr == $past(idx_addr))
      else $error("indexed address wrong");
   a_ptr_high: assert property (take_hi && (word_sel != 2'h3) |=> // [RULE_06]
      cur_ptr[11:8] == $past(i_instr[3:0]) && o_second_word)
      else $error("pointer high part wrong");
   a_ptr_low: assert property (take_lo && (sel_r != 2'h3) |=> // [RULE_10]
      cur_ptr[7:0] == $past(f_addr) && !o_second_word
      && cur_ptr[11:8] == $past(cur_ptr[11:8]))
      else $error("pointer low byte wrong");
   a_second_word: assert property (take_hi ##1 i_instr_valid |=> // [RULE_07]
      !o_file_re && !o_second_word)
      else $error("second word decoded as opcode");

   c_or_file: cover property (take_or && bit_d ##2 o_file_we);
   c_move_w: cover property (take_mov && !bit_d ##2 o_w_we);
   c_ptr_load: cover property (take_hi ##1 take_lo);
   c_indexed: cover property (take_mov && use_idx);
endmodule

// file: verification/olx_prog_mem.sv
// program memory model streaming instruction words to the executor
`timescale 1ns/1ps
module olx_prog_mem (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_slow,
   output logic      [15:0] o_instr,
   output logic             o_valid
);
   logic [15:0] q[$];
   logic        gap_r;

   // ----------------------------------------------------------------
   // word queue
   // ----------------------------------------------------------------
   // bench appends words here
   task automatic put(input logic [15:0] w);
      q.push_back(w);
   endtask

   // one word a cycle, every other cycle when slow; idle bus toggles
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_instr <= 16'h0000;
         o_valid <= 1'b0;
         gap_r   <= 1'b0;
      end else begin
         gap_r <= ~gap_r;
         if (q.size() != 0 && (!i_slow || gap_r)) begin
            o_instr <= q.pop_front();
            o_valid <= 1'b1;
         end else begin
            o_instr <= ~o_instr;
            o_valid <= 1'b0;
         end
      end
   end
endmodule

// file: verification/olx_instr_exec_tb.sv
// self-checking bench for the or/move/pointer-load executor
`timescale 1ns/1ps
module olx_instr_exec_tb;
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  res;
      logic        to_w;
   } olx_exp_type;
   logic        clk, reset_n, slow, valid, ext_en, pend;
   logic        file_re, file_we, w_we, stat_we, stat_n, stat_z, second_word;
   logic [15:0] instr;
   logic [7:0]  w_data, file_rdata, result;
   logic [3:0]  bank_sel;
   logic [11:0] raddr, waddr;
   logic [35:0] ptrs, ptr_m;
   olx_exp_type exp_q[$];
   olx_exp_type pr;
   int          bad_count, num_checks;

   // ----------------------------------------------------------------
   // clock, partner, design, data memory
   // ----------------------------------------------------------------
   initial clk = 1'b0;
   always #20 clk = ~clk;
   olx_prog_mem u_pm (.i_clk(clk), .i_reset_n(reset_n), .i_slow(slow),
      .o_instr(instr), .o_valid(valid));
   olx_instr_exec u_dut (.i_clk(clk), .i_reset_n(reset_n), .i_instr_valid(valid),
      .i_instr(instr), .i_w_data(w_data), .i_file_rdata(file_rdata),
      .i_bank_sel(bank_sel), .i_ext_en(ext_en), .o_file_raddr(raddr),
      .o_file_re(file_re), .o_file_waddr(waddr), .o_file_we(file_we), .o_w_we(w_we),
      .o_result(result), .o_stat_we(stat_we), .o_stat_n(stat_n), .o_stat_z(stat_z),
      .o_second_word(second_word), .o_ptrs(ptrs));
   // file contents derived from the address; zero where low byte equals bank twice
   function automatic logic [7:0] fdat(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], a[11:8]};
   endfunction
   assign file_rdata = file_re ? fdat(raddr) : ~fdat(raddr);

   // ----------------------------------------------------------------
   // checking helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [35:0] seen, input logic [35:0] want);
      num_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("FAIL %0t: saw %h want %h", $time, seen, want);
      end
   endtask

   task automatic final_report();
      if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // read stage, then write stage one cycle later, against queued expectations
   always @(negedge clk) begin
      if (reset_n) begin
         chk(36'(w_we | file_we), 36'(pend));
         if (pend) begin
            chk(36'(w_we), 36'(pr.to_w));
            chk(36'(result), 36'(pr.res));
            chk(36'({stat_we, stat_n, stat_z}), 36'({1'b1, pr.res[7], pr.res == 8'h00}));
            if (!pr.to_w) chk(36'(waddr), 36'(pr.addr));
         end
         pend = file_re && exp_q.size() != 0;
         if (file_re && exp_q.size() == 0) chk(36'h1, 36'h0);
         if (pend) begin
            pr = exp_q.pop_front();
            chk(36'(raddr), 36'(pr.addr));
         end
      end else begin
         pend = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // stimulus helpers
   // ----------------------------------------------------------------
   task automatic setup(input logic [3:0] b, input logic x, input logic [7:0] w);
      @(posedge clk);
      bank_sel <= b;
      ext_en   <= x;
      w_data   <= w;
      @(negedge clk);
   endtask

   // queue one or/move word and its expected address and result
   task automatic op(input logic is_or, input logic d, input logic a, input logic [7:0] f);
      olx_exp_type e;
      if (a) e.addr = {bank_sel, f};
      else if (ext_en && f <= olx_pkg::IDX_LIMIT) e.addr = ptr_m[35:24] + {4'h0, f};
      else e.addr = {(f <= olx_pkg::IDX_LIMIT) ? 4'h0 : 4'hF, f};
      e.res  = is_or ? (w_data | fdat(e.addr)) : fdat(e.addr);
      e.to_w = !d;
      exp_q.push_back(e);
      u_pm.put({is_or ? olx_pkg::OR_PREFIX : olx_pkg::MOVE_PREFIX, d, a, f});
   endtask

   task automatic drain();
      int n;
      n = 0;
      while ((u_pm.q.size() != 0 || exp_q.size() != 0) && n < 40) begin
         @(negedge clk);
         n++;
      end
      repeat (3) @(negedge clk);
      chk(36'(exp_q.size()), 36'h0);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      ptr_m = 36'h0;
      @(negedge clk);
      chk(36'({second_word, stat_z, stat_n, file_re, w_we, file_we, stat_we}), 36'h20);
      chk(ptrs, 36'h0);
   endtask

   // all four selects, one in slow fetch; select 3 loads nothing
   // second word shaped like an or opcode, so a wrong decode reads the file
   task automatic t_ptr_load();
      logic [11:0] k;
      int          n;
      for (int s = 0; s < 4; s++) begin
         k = (s == 2) ? 12'hFF0 : 12'h3AB + 12'(s);
         @(posedge clk);
         slow <= (s == 1);
         @(negedge clk);
         u_pm.put({olx_pkg::LOAD_PREFIX, 2'(s), k[11:8]});
         u_pm.put({8'h13, k[7:0]});
         n = 0;
         while (second_word !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
         end
         if (s < 3) ptr_m[s*12+8 +: 4] = k[11:8];
         chk(ptrs, ptr_m);
         while (second_word !== 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
         end
         if (s < 3) ptr_m[s*12 +: 8] = k[7:0];
         chk(ptrs, ptr_m);
         chk(36'(n < 40), 36'h1);
      end
      @(posedge clk);
      slow <= 1'b0;
   endtask

   // banked, back to back, top of bank, zero and negative results
   task automatic t_banked();
      setup(4'h5, 1'b0, 8'h81);
      op(1'b1, 1'b1, 1'b1, 8'hFF);
      op(1'b1, 1'b0, 1'b1, 8'h00);
      op(1'b0, 1'b0, 1'b1, 8'h55);
      op(1'b0, 1'b1, 1'b1, 8'h80);
      drain();
   endtask

   // access bank split either side of the limit
   task automatic t_access();
      setup(4'h7, 1'b0, 8'h10);
      op(1'b1, 1'b0, 1'b0, 8'h5F);
      op(1'b0, 1'b1, 1'b0, 8'h60);
      op(1'b1, 1'b1, 1'b0, 8'h00);
      drain();
   endtask

   // indexed offset from pointer 2 with wrap, above limit, banked unaffected
   task automatic t_indexed();
      setup(4'h3, 1'b1, 8'h02);
      op(1'b0, 1'b0, 1'b0, 8'h5F);
      op(1'b1, 1'b1, 1'b0, 8'h60);
      op(1'b0, 1'b0, 1'b1, 8'h10);
      drain();
   endtask

   // foreign opcodes leave no trace, decoding resumes after them
   task automatic t_ignored();
      setup(4'h1, 1'b0, 8'h00);
      u_pm.put(16'h0935);
      u_pm.put(16'h1C12);
      u_pm.put(16'hEEC0);
      op(1'b1, 1'b0, 1'b1, 8'h01);
      drain();
      chk(ptrs, ptr_m);
      chk(36'(second_word), 36'h0);
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      reset_n    = 1'b0;
      slow       = 1'b0;
      ext_en     = 1'b0;
      bank_sel   = 4'h0;
      w_data     = 8'h00;
      ptr_m      = 36'h0;
      pend       = 1'b0;
      bad_count  = 0;
      num_checks = 0;
      t_reset();
      t_ptr_load();
      t_banked();
      t_access();
      t_indexed();
      t_ignored();
      t_reset();
      final_report();
   end

   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      final_report();
   end
endmodule
